// File: design/drive_power_start_sequencer.sv
// Module: operating state machine for a drive with separate power stage.
// Assumes a register master with one-cycle strobes and core_clk at 50 MHz.
// Function
// - Control stage runs and answers while power stage supply is absent.
// - Ready state reports 21 hex without supply, 31 hex with supply.
// - Supply absent in switched on past timeout raises contactor error.
// - Contactor variant keeps contactor open before switch-on.
// - Contactor variant closes contactor on switch-on in ready state.
//
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/10ps
module drive_power_start_sequencer (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Register port
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [15:0] rdata,
  // Power stage
  input wire logic power_stage_present,
  output logic contactor_close,
  output logic no_power_stage_indication,
  // Motor side
  output logic [15:0] motor_speed_ref,
  output logic irq
);
  import dps_pkg::*;

  dps_tmo_if tmo_if ();

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  op_state_e state_ff, nxt_state;
  logic [15:0] cw_ff, nxt_cw;
  logic cw_new_ff, nxt_cw_new;
  logic fr_prev_ff, nxt_fr_prev;
  logic cfg_cont_ff, nxt_cfg_cont;
  logic [15:0] tmo_ff, nxt_tmo;
  logic [15:0] sref_ff, nxt_sref;
  logic [2:0] ista_ff, nxt_ista;
  logic [2:0] imask_ff, nxt_imask;
  logic [15:0] rdata_ff, nxt_rdata;
  logic cont_ff, nxt_cont;
  logic nlp_ff, nxt_nlp;
  logic [15:0] mref_ff, nxt_mref;
  logic irq_ff, nxt_irq;
  logic pwr_prev_ff, nxt_pwr_prev;
  logic [15:0] status_word;
  logic [15:0] cmd;
  logic fault_edge;
  logic contactor_err;

  // Status word built from operating state and supply presence
  function automatic logic [15:0] state_word(op_state_e s, logic volt);
    logic [15:0] w;
    w = SW_NOT_READY;
    unique case (s)
      ST_NOT_READY: w = SW_NOT_READY;
      ST_SW_ON_DIS: w = SW_SW_ON_DIS;
      ST_READY: w = SW_READY;
      ST_SWITCHED_ON: w = SW_SWITCHED_ON;
      ST_OP_ENABLED: w = SW_OP_ENABLED;
      ST_FAULT: w = SW_FAULT;
    endcase
    w[SW_BIT_VOLT] = volt;
    return w;
  endfunction

  assign status_word = state_word(state_ff, power_stage_present);
  assign cmd = cw_ff & CW_MASK_CMD;
  assign fault_edge = cw_ff[CW_BIT_FAULT_RST] & ~fr_prev_ff;
  assign contactor_err = tmo_if.expired & ~power_stage_present;

  // ------------------------------------------------------------------
  // Timeout timer
  // ------------------------------------------------------------------
  // Runs only in switched on while the supply is missing
  assign tmo_if.run = (state_ff == ST_SWITCHED_ON) & ~power_stage_present;
  assign tmo_if.limit_ms = tmo_ff;

  dps_mains_timer u_timer (
    .core_clk(core_clk),
    .srst(srst),
    .tmo(tmo_if.timer)
  );

  // ------------------------------------------------------------------
  // Operating state machine
  // ------------------------------------------------------------------
  // Commands are acted on once per control word write
  always_comb begin
    nxt_state = state_ff;
    nxt_fr_prev = fr_prev_ff;
    if (cw_new_ff) begin
      nxt_fr_prev = cw_ff[CW_BIT_FAULT_RST];
    end
    unique case (state_ff)
      ST_NOT_READY: nxt_state = ST_SW_ON_DIS;
      ST_SW_ON_DIS:
        if (cw_new_ff && cmd == CW_SHUTDOWN) begin
          nxt_state = ST_READY;
        end
      ST_READY:
        if (cw_new_ff) begin
          if (cmd == CW_SWITCH_ON) begin
            nxt_state = ST_SWITCHED_ON;
          end else if (cmd == CW_ENABLE_OP) begin
            nxt_state = ST_OP_ENABLED;
          end else if (cmd != CW_SHUTDOWN) begin
            nxt_state = ST_SW_ON_DIS;
          end
        end
      ST_SWITCHED_ON:
        if (contactor_err) begin
          nxt_state = ST_FAULT;
        end else if (cw_new_ff) begin
          if (cmd == CW_ENABLE_OP) begin
            nxt_state = ST_OP_ENABLED;
          end else if (cmd == CW_SHUTDOWN) begin
            nxt_state = ST_READY;
          end else if (cmd != CW_SWITCH_ON) begin
            nxt_state = ST_SW_ON_DIS;
          end
        end
      ST_OP_ENABLED:
        if (cw_new_ff) begin
          if (cmd == CW_SWITCH_ON) begin
            nxt_state = ST_SWITCHED_ON;
          end else if (cmd == CW_SHUTDOWN) begin
            nxt_state = ST_READY;
          end else if (cmd != CW_ENABLE_OP) begin
            nxt_state = ST_SW_ON_DIS;
          end
        end
      ST_FAULT:
        if (cw_new_ff && fault_edge) begin
          nxt_state = ST_SW_ON_DIS;
        end
    endcase
  end

  // ------------------------------------------------------------------
  // Register port, outputs and interrupts
  // ------------------------------------------------------------------
  always_comb begin
    nxt_cw = cw_ff;
    nxt_cw_new = 1'b0;
    nxt_cfg_cont = cfg_cont_ff;
    nxt_tmo = tmo_ff;
    nxt_sref = sref_ff;
    nxt_imask = imask_ff;
    nxt_ista = ista_ff;
    nxt_rdata = 16'h0000;
    nxt_pwr_prev = power_stage_present;
    if (wr_stb) begin
      unique case (addr)
        ADDR_CTRL_WORD: begin
          nxt_cw = wdata;
          nxt_cw_new = 1'b1;
        end
        ADDR_CONFIG: nxt_cfg_cont = wdata[CFG_BIT_CONTACTOR];
        ADDR_MAINS_TMO: nxt_tmo = wdata;
        ADDR_SPEED_REF: nxt_sref = wdata;
        ADDR_IRQ_STATUS: nxt_ista = ista_ff & ~wdata[2:0];
        ADDR_IRQ_MASK: nxt_imask = wdata[2:0];
        default: ;
      endcase
    end
    // Set wins over a write-one clear in the same cycle
    if (contactor_err) begin
      nxt_ista[IRQ_BIT_CONTACTOR_ERR] = 1'b1;
    end
    if (nxt_state != state_ff) begin
      nxt_ista[IRQ_BIT_STATE_CHG] = 1'b1;
    end
    if (power_stage_present != pwr_prev_ff) begin
      nxt_ista[IRQ_BIT_SUPPLY_CHG] = 1'b1;
    end
    if (rd_stb) begin
      unique case (addr)
        ADDR_CTRL_WORD: nxt_rdata = cw_ff;
        ADDR_STATUS_WORD: nxt_rdata = status_word;
        ADDR_CONFIG: nxt_rdata = {15'h0000, cfg_cont_ff};
        ADDR_MAINS_TMO: nxt_rdata = tmo_ff;
        ADDR_SPEED_REF: nxt_rdata = sref_ff;
        ADDR_IRQ_STATUS: nxt_rdata = {13'h0000, ista_ff};
        ADDR_IRQ_MASK: nxt_rdata = {13'h0000, imask_ff};
        default: nxt_rdata = 16'h0000;
      endcase
    end
    // Contactor open until switched on, closed while on or enabled when the contactor config bit is set
    nxt_cont = cfg_cont_ff &
      (state_ff == ST_SWITCHED_ON || state_ff == ST_OP_ENABLED);
    nxt_nlp = ~power_stage_present;
    nxt_mref = (state_ff == ST_OP_ENABLED) ? sref_ff : 16'h0000;
    nxt_irq = |(ista_ff & imask_ff);
  end

  // Register update
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_ff <= ST_NOT_READY;
      cw_ff <= CW_DISABLE_V;
      cw_new_ff <= 1'b0;
      fr_prev_ff <= 1'b0;
      cfg_cont_ff <= 1'b0;
      tmo_ff <= MAINS_TMO_MS_RST;
      sref_ff <= 16'h0000;
      ista_ff <= IRQ_RST;
      imask_ff <= IRQ_RST;
      rdata_ff <= 16'h0000;
      cont_ff <= 1'b0;
      nlp_ff <= 1'b1;
      mref_ff <= 16'h0000;
      irq_ff <= 1'b0;
      pwr_prev_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cw_ff <= nxt_cw;
      cw_new_ff <= nxt_cw_new;
      fr_prev_ff <= nxt_fr_prev;
      cfg_cont_ff <= nxt_cfg_cont;
      tmo_ff <= nxt_tmo;
      sref_ff <= nxt_sref;
      ista_ff <= nxt_ista;
      imask_ff <= nxt_imask;
      rdata_ff <= nxt_rdata;
      cont_ff <= nxt_cont;
      nlp_ff <= nxt_nlp;
      mref_ff <= nxt_mref;
      irq_ff <= nxt_irq;
      pwr_prev_ff <= nxt_pwr_prev;
    end
  end

  assign rdata = rdata_ff;
  assign contactor_close = cont_ff;
  assign no_power_stage_indication = nlp_ff;
  assign motor_speed_ref = mref_ff;
  assign irq = irq_ff;
endmodule // drive_power_start_sequencer

// File: design/dps_pkg.sv
// Package: shared constants for the drive power start sequencer.
// Assumes a 50 MHz core clock; register port and state codes live here.
package dps_pkg;

  // ------------------------------------------------------------------
  // Clock and timing
  // ------------------------------------------------------------------
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned MS_CYCLES = CLK_HZ / 1000;
  localparam logic [15:0] MAINS_TMO_MS_RST = 16'h0BB8;

  // ------------------------------------------------------------------
  // Register offsets (word addresses)
  // ------------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL_WORD = 4'h0;
  localparam logic [3:0] ADDR_STATUS_WORD = 4'h1;
  localparam logic [3:0] ADDR_CONFIG = 4'h2;
  localparam logic [3:0] ADDR_MAINS_TMO = 4'h3;
  localparam logic [3:0] ADDR_SPEED_REF = 4'h4;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h5;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h6;

  // ------------------------------------------------------------------
  // Control word fields and command codes
  // ------------------------------------------------------------------
  localparam logic [15:0] CW_MASK_CMD = 16'h008F;
  localparam logic [15:0] CW_SHUTDOWN = 16'h0006;
  localparam logic [15:0] CW_SWITCH_ON = 16'h0007;
  localparam logic [15:0] CW_ENABLE_OP = 16'h000F;
  localparam logic [15:0] CW_DISABLE_V = 16'h0000;
  localparam logic [15:0] CW_QUICK_STOP = 16'h0002;
  localparam int unsigned CW_BIT_FAULT_RST = 7;

  // ------------------------------------------------------------------
  // Status word encodings (bit 4 is voltage enabled)
  // ------------------------------------------------------------------
  localparam logic [15:0] SW_NOT_READY = 16'h0000;
  localparam logic [15:0] SW_SW_ON_DIS = 16'h0040;
  localparam logic [15:0] SW_READY = 16'h0021;
  localparam logic [15:0] SW_SWITCHED_ON = 16'h0023;
  localparam logic [15:0] SW_OP_ENABLED = 16'h0027;
  localparam logic [15:0] SW_FAULT = 16'h0008;
  localparam int unsigned SW_BIT_VOLT = 4;

  // ------------------------------------------------------------------
  // Config and interrupt bit positions
  // ------------------------------------------------------------------
  localparam int unsigned CFG_BIT_CONTACTOR = 0;
  localparam int unsigned IRQ_BIT_CONTACTOR_ERR = 0;
  localparam int unsigned IRQ_BIT_STATE_CHG = 1;
  localparam int unsigned IRQ_BIT_SUPPLY_CHG = 2;
  localparam logic [2:0] IRQ_RST = 3'h0;

  // Drive operating states
  typedef enum logic [2:0] {
    ST_NOT_READY,
    ST_SW_ON_DIS,
    ST_READY,
    ST_SWITCHED_ON,
    ST_OP_ENABLED,
    ST_FAULT
  } op_state_e;

endpackage

// File: design/dps_tmo_if.sv
// Interface: link between the sequencer and its mains timeout timer.
// Assumes both ends share core_clk.
`timescale 1ns/10ps
interface dps_tmo_if;
  logic run;
  logic [15:0] limit_ms;
  logic expired;
  modport ctrl (output run, output limit_ms, input expired);
  modport timer (input run, input limit_ms, output expired);
endinterface // dps_tmo_if

// File: design/dps_mains_timer.sv
// Module: millisecond timeout timer for the power stage supply check.
// Assumes core_clk at the package rate and synchronous active-high reset.
`timescale 1ns/10ps
module dps_mains_timer (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Control
  dps_tmo_if.timer tmo
);
  import dps_pkg::*;

  logic [15:0] pre_ff, nxt_pre;
  logic [15:0] ms_ff, nxt_ms;
  logic exp_ff, nxt_exp;

  // Count milliseconds while run is high, clear when dropped
  always_comb begin
    nxt_pre = pre_ff;
    nxt_ms = ms_ff;
    nxt_exp = exp_ff;
    if (!tmo.run) begin
      nxt_pre = 16'h0000;
      nxt_ms = 16'h0000;
      nxt_exp = 1'b0;
    end else if (!exp_ff) begin
      if (pre_ff == 16'(MS_CYCLES - 1)) begin
        nxt_pre = 16'h0000;
        nxt_ms = ms_ff + 16'h0001;
      end else begin
        nxt_pre = pre_ff + 16'h0001;
      end
      if (ms_ff >= tmo.limit_ms) begin
        nxt_exp = 1'b1;
      end
    end
  end

  // State registers
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pre_ff <= 16'h0000;
      ms_ff <= 16'h0000;
      exp_ff <= 1'b0;
    end else begin
      pre_ff <= nxt_pre;
      ms_ff <= nxt_ms;
      exp_ff <= nxt_exp;
    end
  end

  assign tmo.expired = exp_ff;
endmodule // dps_mains_timer

// File: bench/dps_sva.sv
// Checker: port assertions for the drive power start sequencer.
// Assumes it is bound to the top module; one clock domain.
`timescale 1ns/10ps
module dps_sva import dps_pkg::*; (
  // Clock, reset and register port
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [15:0] rdata,
  // Power stage and motor
  input wire logic power_stage_present,
  input wire logic contactor_close,
  input wire logic no_power_stage_indication,
  input wire logic [15:0] motor_speed_ref,
  input wire logic irq
);
  // ------------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  logic cw_shut;
  // Shutdown written to the control word
  assign cw_shut = wr_stb && addr == ADDR_CTRL_WORD && wdata == CW_SHUTDOWN;
  rdata_idle_a: assert property (!$past(rd_stb) |-> rdata == 16'h0000)
    else $error("read data outside read cycle");
  unmapped_rd_a: assert property (rd_stb && addr > ADDR_IRQ_MASK
    |=> rdata == 16'h0000) else $error("unmapped read not zero");
  volt_bit_a: assert property (rd_stb && addr == ADDR_STATUS_WORD
    ##1 (rdata & 16'h006F) == SW_READY && $stable(power_stage_present)
    |-> rdata[SW_BIT_VOLT] == power_stage_present) else $error("volt bit");
  ind_follow_a: assert property (!no_power_stage_indication
    |-> $past(power_stage_present)) else $error("supply indication");
  contactor_open_a: assert property (cw_shut |-> ##4 !contactor_close)
    else $error("contactor closed after shutdown");
  speed_off_a: assert property (cw_shut |-> ##4 motor_speed_ref == 16'h0000)
    else $error("speed reference after shutdown");
  irq_mask_a: assert property (wr_stb && addr == ADDR_IRQ_MASK
    && wdata[2:0] == 3'h0 |-> ##2 !irq) else $error("masked irq high");
  reset_vals_a: assert property ($fell(srst) |-> !contactor_close && !irq
    && no_power_stage_indication && motor_speed_ref == 16'h0000)
    else $error("reset values");
  cover property ($rose(contactor_close));
  cover property ($rose(irq));
  cover property (motor_speed_ref != 16'h0000);
endmodule // dps_sva

bind drive_power_start_sequencer dps_sva dps_sva_i (.core_clk(core_clk),
  .srst(srst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
  .rd_stb(rd_stb), .rdata(rdata), .irq(irq),
  .power_stage_present(power_stage_present),
  .contactor_close(contactor_close), .motor_speed_ref(motor_speed_ref),
  .no_power_stage_indication(no_power_stage_indication));

// File: bench/dps_plc_model.sv
// Model: fieldbus master issuing register accesses and polling state.
// Assumes the bench calls its tasks after reset.
`timescale 1ns/10ps
module dps_plc_model (
  // Clock
  input wire logic core_clk,
  // Register port
  output logic [3:0] addr,
  output logic [15:0] wdata,
  output logic wr_stb,
  output logic rd_stb,
  input wire logic [15:0] rdata
);
  import dps_pkg::*;
  // ------------------------------------------------------------------
  // Bus cycles
  // ------------------------------------------------------------------
  initial begin
    addr = 4'h0;
    wdata = 16'h0000;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
  end
  // One-cycle write; data inverted once released
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge core_clk);
    wr_stb <= 1'b0;
    wdata <= ~d;
  endtask
  // One-cycle read; data taken in the following cycle
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge core_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge core_clk);
    rd_stb <= 1'b0;
    #1;
    d = rdata;
  endtask
  // Poll masked state before the next command; stop on fault
  task automatic wait_state(input logic [15:0] exp, output logic ok);
    logic [15:0] s;
    ok = 1'b0;
    for (int i = 0; i < 20 && !ok; i++) begin
      rd(ADDR_STATUS_WORD, s);
      if (s[3] && exp != SW_FAULT) break;
      ok = ((s & 16'h006F) === exp);
    end
  endtask
endmodule // dps_plc_model

// File: bench/drive_power_start_sequencer_tb_top.sv
// Testbench: start-up with separate supply and with mains contactor.
// Assumes the master model drives the register port.
`timescale 1ns/10ps
module drive_power_start_sequencer_tb_top;
  import dps_pkg::*;
  logic core_clk, srst, wr_stb, rd_stb, irq, ok, mains_mode, pwr_manual;
  logic power_stage_present, contactor_close, no_power_stage_indication;
  logic [3:0] addr;
  logic [15:0] wdata, rdata, motor_speed_ref, v;
  int error_cnt;
  int check_count;
  // ------------------------------------------------------------------
  // Instances, clock and helpers
  // ------------------------------------------------------------------
  drive_power_start_sequencer drive_power_start_sequencer_i (
    .core_clk(core_clk), .srst(srst), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .irq(irq),
    .power_stage_present(power_stage_present),
    .contactor_close(contactor_close), .motor_speed_ref(motor_speed_ref),
    .no_power_stage_indication(no_power_stage_indication));
  dps_plc_model dps_plc_model_i (.core_clk(core_clk), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata));
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // Supply: manual level, or follows the contactor in the contactor variant
  always @(posedge core_clk) begin
    power_stage_present <= mains_mode ? contactor_close : pwr_manual;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [15:0] exp);
    dps_plc_model_i.rd(a, v);
    check(v, exp);
  endtask
  // Command then wait for the expected state
  task automatic step(input logic [15:0] cmd, input logic [15:0] exp);
    dps_plc_model_i.wr(ADDR_CTRL_WORD, cmd);
    dps_plc_model_i.wait_state(exp, ok);
    check({15'h0000, ok}, 16'h0001);
  endtask
  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    srst = 1'b1;
    pwr_manual = 1'b0;
    mains_mode = 1'b0;
    error_cnt = 0;
    check_count = 0;
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    rchk(ADDR_STATUS_WORD, SW_SW_ON_DIS);
    rchk(4'hF, 16'h0000);
    rchk(ADDR_MAINS_TMO, MAINS_TMO_MS_RST);
    dps_plc_model_i.wr(ADDR_MAINS_TMO, 16'h0001);
    step(CW_SHUTDOWN, SW_READY);
    rchk(ADDR_STATUS_WORD, 16'h0021);
    pwr_manual <= 1'b1;
    repeat (3) @(posedge core_clk);
    rchk(ADDR_STATUS_WORD, 16'h0031);
    check({15'h0000, no_power_stage_indication}, 16'h0000);
    dps_plc_model_i.wr(ADDR_SPEED_REF, 16'h0123);
    step(CW_SWITCH_ON, SW_SWITCHED_ON);
    check(motor_speed_ref, 16'h0000);
    step(CW_ENABLE_OP, SW_OP_ENABLED);
    check(motor_speed_ref, 16'h0123);
    // Supply missing while switched on
    step(CW_SHUTDOWN, SW_READY);
    pwr_manual <= 1'b0;
    dps_plc_model_i.wr(ADDR_IRQ_STATUS, 16'h0007);
    dps_plc_model_i.wr(ADDR_IRQ_MASK, 16'h0001);
    step(CW_SWITCH_ON, SW_SWITCHED_ON);
    for (int i = 0; i < 60000 && irq !== 1'b1; i++) @(posedge core_clk);
    check({15'h0000, irq}, 16'h0001);
    if (irq !== 1'b1) complete_run;
    rchk(ADDR_STATUS_WORD, SW_FAULT);
    dps_plc_model_i.rd(ADDR_IRQ_STATUS, v);
    check(v & 16'h0001, 16'h0001);
    dps_plc_model_i.wr(ADDR_IRQ_STATUS, 16'h0007);
    repeat (3) @(posedge core_clk);
    check({15'h0000, irq}, 16'h0000);
    // Contactor variant
    step(16'h0080, SW_SW_ON_DIS);
    dps_plc_model_i.wr(ADDR_CONFIG, 16'h0001);
    mains_mode <= 1'b1;
    step(CW_SHUTDOWN, SW_READY);
    check({15'h0000, contactor_close}, 16'h0000);
    rchk(ADDR_STATUS_WORD, 16'h0021);
    step(CW_SWITCH_ON, SW_SWITCHED_ON);
    check({15'h0000, contactor_close}, 16'h0001);
    repeat (3) @(posedge core_clk);
    rchk(ADDR_STATUS_WORD, 16'h0033);
    // State change and supply change pending, contactor error cleared
    rchk(ADDR_IRQ_STATUS, 16'h0006);
    // Unmask the pending events, then mask everything again
    dps_plc_model_i.wr(ADDR_IRQ_MASK, 16'h0006);
    repeat (2) @(posedge core_clk);
    check({15'h0000, irq}, 16'h0001);
    dps_plc_model_i.wr(ADDR_IRQ_MASK, 16'h0000);
    repeat (2) @(posedge core_clk);
    check({15'h0000, irq}, 16'h0000);
    complete_run;
  end
endmodule // drive_power_start_sequencer_tb_top
